// file: src/adcrp_pkg.sv
// constants and types shared by the two-wire register port
package adcrp_pkg;
  // register selector codes
  localparam logic [1:0]  PTR_CONV      = 2'h0;
  localparam logic [1:0]  PTR_CFG       = 2'h1;
  localparam logic [1:0]  PTR_LO        = 2'h2;
  localparam logic [1:0]  PTR_HI        = 2'h3;
  // reset values
  localparam logic [15:0] CONV_RESET    = 16'h0000;
  localparam logic [15:0] CFG_RESET     = 16'h8583;
  localparam logic [15:0] LO_RESET      = 16'h8000;
  localparam logic [15:0] HI_RESET      = 16'h7fff;
  localparam logic [3:0]  CONV_PAD      = 4'h0;
  // configuration field positions
  localparam int          CFG_OS_BIT    = 15;
  localparam int          MUX_MSB       = 14;
  localparam int          MUX_LSB       = 12;
  localparam int          GAIN_MSB      = 11;
  localparam int          GAIN_LSB      = 9;
  localparam int          MODE_BIT      = 8;
  localparam int          RATE_MSB      = 7;
  localparam int          RATE_LSB      = 5;
  localparam int          KIND_BIT      = 4;
  localparam int          POL_BIT       = 3;
  localparam int          LAT_BIT       = 2;
  localparam int          QUE_MSB       = 1;
  localparam int          QUE_LSB       = 0;
  // bus codes
  localparam logic [4:0]  ADDR_UPPER    = 5'h12;
  localparam logic [7:0]  GCALL_BYTE    = 8'h00;
  localparam logic [7:0]  GCALL_RESET   = 8'h06;
  localparam logic [4:0]  HS_CODE_TOP   = 5'h01;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT   = 4'h7;
  localparam logic [7:0]  IDLE_BYTE     = 8'hff;
  localparam logic [1:0]  WB_MSB        = 2'h0;
  localparam logic [1:0]  WB_LSB        = 2'h1;
  localparam logic [1:0]  WB_DONE       = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_DATA,
    ST_GC,
    ST_ACK,
    ST_TX,
    ST_MACK
  } adcrp_state_t;
endpackage

// file: src/adcrp_sync.sv
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module adcrp_sync #(
  parameter int WIDTH = 1 // bits synchronised side by side
) (
  input  wire logic             clk, // destination clock
  input  wire logic [WIDTH-1:0] d,   // level from a pin or another domain
  output logic      [WIDTH-1:0] q    // synchronised level
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk)
  begin
    meta_reg <= d;
    q_reg    <= meta_reg;
  end

  assign q = q_reg;
endmodule

// file: src/adcrp_port.sv
// two-wire slave register port of a 12-bit converter
`timescale 1ns/1ps
// Overview of operation
// RL1: after a write-direction address byte, next byte is the pointer, acknowledged.
// RL2: two data bytes after the pointer go to the selected register, each acknowledged.
// RL3: sixteen-bit words travel high byte first, then low byte.
// RL4: read-direction address makes the device send upper then lower byte of selected register.
// RL5: master nack, start or stop ends a read; device releases data line.
// RL6: master sends pointer right after write address, then stop or repeated start.
// RL7: pointer holds across transactions; reads use the last pointer written.
// RL8: every master write carries a pointer byte first.
// RL9: pointer-only write followed by stop is accepted and changes no register.
// RL10: master opens each transaction with start and closes it with stop.
// RL11: device is only slave receiver or transmitter; clock line is input only.
// RL12: pointer bits 1:0 pick conversion, configuration, low limit or high limit.
// RL13: master writes pointer only, with zeros in bits 7 to 2.
// RL14: conversion register holds 12-bit result in bits 15:4, low nibble zero.
// RL15: conversion register reads zero after reset until a conversion completes.
// RL16: configuration register is read/write and resets to 8583h.
// RL17: configuration fields: start flag, input, gain, mode, rate, comparator bits.
// RL18: two low address bits come from the strap; upper bits fixed 10010.
// RL19: strap sampled continuously; its four codes give the four addresses.
// RL20: general call with write is acknowledged; second byte 06h resets and powers down.
// RL21: high-speed master code is not acknowledged; high-speed lasts until next stop.
// RL22: writing start flag 1 while powered down begins one conversion; reads 0 while busy.
// RL23: data written to the conversion register are acknowledged and discarded.
module adcrp_port (
  input  wire logic        clk,            // core clock, 100 MHz
  input  wire logic        rst_b,          // synchronous reset, active low
  input  wire logic        link_clk,       // oversampling clock of the bus side
  input  wire logic        scl_i,          // bus clock pin level
  input  wire logic        sda_i,          // bus data pin level
  input  wire logic [1:0]  address_strap,  // strap code: gnd, supply, data, clock
  output logic             sda_o,          // data pin drive value, always low
  output logic             sda_oe_n,       // data pin enable, low pulls line low
  output logic             hs_mode,        // high-speed filters on
  input  wire logic [11:0] conv_value,     // converter result
  input  wire logic        conv_done,      // result valid pulse
  output logic             conv_start,     // begin one conversion, pulse
  output logic [2:0]       input_select,   // input selection field
  output logic [2:0]       gain_select,    // gain field
  output logic             op_mode,        // operating mode, 1 single-shot
  output logic [2:0]       rate_select,    // data rate field
  output logic             comp_kind,      // comparator kind
  output logic             alert_polarity, // alert polarity
  output logic             alert_latch,    // alert latch
  output logic [1:0]       alert_queue,    // alert queue
  output logic [15:0]      low_limit,      // low limit register
  output logic [15:0]      high_limit      // high limit register
);
  // ----------------------------------------------------------------
  // bus side: synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [5:0]                lsync_q;
  logic                      link_rst_b;
  logic                      scl_s;
  logic                      sda_s;
  logic [1:0]                strap_s;
  logic                      ack_s;
  logic                      rd_ack_tgl_reg;
  logic                      scl_q_reg;
  logic                      sda_q_reg;
  logic                      start_det;
  logic                      stop_det;
  logic                      scl_rise;
  logic                      scl_fall;
  logic [6:0]                dev_addr;

  // reset also crosses so the bus side leaves reset on its own clock
  adcrp_sync #(.WIDTH(6)) u_lsync (
    .clk (link_clk),
    .d   ({rst_b, scl_i, sda_i, address_strap, rd_ack_tgl_reg}),
    .q   (lsync_q)
  );

  assign link_rst_b = lsync_q[5];
  assign scl_s      = lsync_q[4];
  assign sda_s      = lsync_q[3];
  assign strap_s    = lsync_q[2:1];
  assign ack_s      = lsync_q[0];
  assign start_det  = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign stop_det   = scl_s && scl_q_reg && !sda_q_reg && sda_s;
  assign scl_rise   = scl_s && !scl_q_reg;
  assign scl_fall   = !scl_s && scl_q_reg;
  assign dev_addr   = {adcrp_pkg::ADDR_UPPER, strap_s}; // RL18 RL19

  // ----------------------------------------------------------------
  // bus side: byte engine
  // ----------------------------------------------------------------
  adcrp_pkg::adcrp_state_t st_reg, st_next, after_reg, after_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [7:0]  shift_reg, shift_next;
  logic        oe_n_reg, oe_n_next;
  logic        hs_reg, hs_next;
  logic [1:0]  ptr_reg, ptr_next;
  logic [1:0]  wcnt_reg, wcnt_next;
  logic [7:0]  msb_reg, msb_next;
  logic        lsb_sent_reg, lsb_sent_next;
  logic        mack_reg, mack_next;
  logic        ev_tgl_reg, ev_tgl_next;
  logic        ev_gc_reg, ev_gc_next;
  logic [15:0] ev_data_reg, ev_data_next;
  logic        rd_tgl_reg, rd_tgl_next;
  logic        ack_seen_reg;
  logic        snap_ok_reg, snap_ok_next;
  logic        sda_o_reg;
  logic [15:0] snap_reg;
  logic [7:0]  tx_byte;

  always_comb
  begin
    st_next       = st_reg;
    after_next    = after_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    oe_n_next     = oe_n_reg;
    hs_next       = hs_reg;
    ptr_next      = ptr_reg;
    wcnt_next     = wcnt_reg;
    msb_next      = msb_reg;
    lsb_sent_next = lsb_sent_reg;
    mack_next     = mack_reg;
    ev_tgl_next   = ev_tgl_reg;
    ev_gc_next    = ev_gc_reg;
    ev_data_next  = ev_data_reg;
    rd_tgl_next   = rd_tgl_reg;
    snap_ok_next  = snap_ok_reg | (ack_s ^ ack_seen_reg);
    // a word not yet back from the core goes out as released bits
    tx_byte       = lsb_sent_reg ? snap_reg[7:0] : snap_reg[15:8]; // RL3
    if (!snap_ok_reg)
      tx_byte = adcrp_pkg::IDLE_BYTE;
    if (start_det)
    begin
      st_next   = adcrp_pkg::ST_ADDR;
      cnt_next  = '0;
      oe_n_next = 1'b1; // RL5
    end
    else if (stop_det)
    begin
      st_next   = adcrp_pkg::ST_IDLE;
      oe_n_next = 1'b1; // RL5
      hs_next   = 1'b0; // RL21
    end
    else
    begin
      unique case (st_reg)
        adcrp_pkg::ST_IDLE:
        begin
          cnt_next = '0;
        end
        adcrp_pkg::ST_ADDR, adcrp_pkg::ST_PTR, adcrp_pkg::ST_DATA, adcrp_pkg::ST_GC:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = 4'(cnt_reg + 4'h1);
          end
          else if (scl_fall && cnt_reg == adcrp_pkg::BITS_PER_BYTE)
          begin
            cnt_next   = '0;
            oe_n_next  = 1'b0;
            st_next    = adcrp_pkg::ST_ACK;
            after_next = adcrp_pkg::ST_IDLE;
            if (st_reg == adcrp_pkg::ST_ADDR)
            begin
              if (shift_reg[7:1] == dev_addr && shift_reg[0]) // RL4
              begin
                after_next    = adcrp_pkg::ST_TX;
                rd_tgl_next   = ~rd_tgl_reg;
                snap_ok_next  = 1'b0;
                lsb_sent_next = 1'b0;
              end
              else if (shift_reg[7:1] == dev_addr)
                after_next = adcrp_pkg::ST_PTR; // RL1
              else if (shift_reg == adcrp_pkg::GCALL_BYTE)
                after_next = adcrp_pkg::ST_GC; // RL20
              else
              begin
                oe_n_next = 1'b1;
                st_next   = adcrp_pkg::ST_IDLE;
                hs_next   = hs_reg | (shift_reg[7:3] == adcrp_pkg::HS_CODE_TOP); // RL21
              end
            end
            else if (st_reg == adcrp_pkg::ST_PTR)
            begin
              ptr_next   = shift_reg[1:0]; // RL1 RL7 RL12
              wcnt_next  = adcrp_pkg::WB_MSB;
              after_next = adcrp_pkg::ST_DATA;
            end
            else if (st_reg == adcrp_pkg::ST_DATA)
            begin
              after_next = adcrp_pkg::ST_DATA; // RL2
              if (wcnt_reg == adcrp_pkg::WB_MSB)
              begin
                msb_next  = shift_reg; // RL3
                wcnt_next = adcrp_pkg::WB_LSB;
              end
              else if (wcnt_reg == adcrp_pkg::WB_LSB)
              begin
                ev_data_next = {msb_reg, shift_reg}; // RL2 RL3
                ev_gc_next   = 1'b0;
                ev_tgl_next  = ~ev_tgl_reg; // RL9
                wcnt_next    = adcrp_pkg::WB_DONE;
              end
            end
            else if (shift_reg == adcrp_pkg::GCALL_RESET)
            begin
              ev_gc_next  = 1'b1; // RL20
              ev_tgl_next = ~ev_tgl_reg;
              ptr_next    = adcrp_pkg::PTR_CONV;
            end
          end
        end
        adcrp_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            st_next   = after_reg;
            cnt_next  = '0;
            oe_n_next = 1'b1;
            if (after_reg == adcrp_pkg::ST_TX)
            begin
              shift_next = tx_byte; // RL4
              oe_n_next  = tx_byte[7];
            end
          end
        end
        adcrp_pkg::ST_TX:
        begin
          if (scl_fall && cnt_reg == adcrp_pkg::TX_LAST_BIT)
          begin
            oe_n_next = 1'b1;
            cnt_next  = '0;
            st_next   = adcrp_pkg::ST_MACK;
          end
          else if (scl_fall)
          begin
            shift_next = {shift_reg[6:0], 1'b1};
            oe_n_next  = shift_reg[6];
            cnt_next   = 4'(cnt_reg + 4'h1);
          end
        end
        adcrp_pkg::ST_MACK:
        begin
          if (scl_rise)
            mack_next = ~sda_s;
          else if (scl_fall && mack_reg && !lsb_sent_reg)
          begin
            lsb_sent_next = 1'b1; // RL3 RL4
            shift_next    = snap_ok_reg ? snap_reg[7:0] : adcrp_pkg::IDLE_BYTE;
            oe_n_next     = snap_ok_reg ? snap_reg[7] : 1'b1;
            st_next       = adcrp_pkg::ST_TX;
          end
          else if (scl_fall)
            st_next = adcrp_pkg::ST_IDLE; // RL5
        end
      endcase
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_b)
    begin
      scl_q_reg    <= 1'b1;
      sda_q_reg    <= 1'b1;
      st_reg       <= adcrp_pkg::ST_IDLE;
      after_reg    <= adcrp_pkg::ST_IDLE;
      cnt_reg      <= '0;
      shift_reg    <= '0;
      oe_n_reg     <= 1'b1;
      hs_reg       <= 1'b0;
      ptr_reg      <= adcrp_pkg::PTR_CONV;
      wcnt_reg     <= adcrp_pkg::WB_DONE;
      msb_reg      <= '0;
      lsb_sent_reg <= 1'b0;
      mack_reg     <= 1'b0;
      ev_tgl_reg   <= 1'b0;
      ev_gc_reg    <= 1'b0;
      ev_data_reg  <= '0;
      rd_tgl_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
      snap_ok_reg  <= 1'b0;
      sda_o_reg    <= 1'b0;
    end
    else
    begin
      scl_q_reg    <= scl_s;
      sda_q_reg    <= sda_s;
      st_reg       <= st_next;
      after_reg    <= after_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      oe_n_reg     <= oe_n_next;
      hs_reg       <= hs_next;
      ptr_reg      <= ptr_next;
      wcnt_reg     <= wcnt_next;
      msb_reg      <= msb_next;
      lsb_sent_reg <= lsb_sent_next;
      mack_reg     <= mack_next;
      ev_tgl_reg   <= ev_tgl_next;
      ev_gc_reg    <= ev_gc_next;
      ev_data_reg  <= ev_data_next;
      rd_tgl_reg   <= rd_tgl_next;
      ack_seen_reg <= ack_s;
      snap_ok_reg  <= snap_ok_next;
      sda_o_reg    <= 1'b0;
    end
  end

  // open drain: only ever pulls low, the clock pin has no driver at all
  assign sda_o    = sda_o_reg;    // RL11
  assign sda_oe_n = oe_n_reg;
  assign hs_mode  = hs_reg;

  // ----------------------------------------------------------------
  // core side: register file
  // ----------------------------------------------------------------
  logic [1:0]  csync_q;
  logic        ev_seen_reg;
  logic        rd_seen_reg;
  logic        ev_fire;
  logic        rd_fire;
  logic        powered_down;
  logic [15:0] conv_reg, conv_next;
  logic [14:0] cfg_reg, cfg_next;
  logic [15:0] lo_reg, lo_next;
  logic [15:0] hi_reg, hi_next;
  logic        busy_reg, busy_next;
  logic        start_reg, start_next;
  logic [15:0] snap_next;
  logic        rd_ack_tgl_next;

  // ptr_reg and ev_data_reg are held for many bit times after each toggle
  adcrp_sync #(.WIDTH(2)) u_csync (
    .clk (clk),
    .d   ({ev_tgl_reg, rd_tgl_reg}),
    .q   (csync_q)
  );

  assign ev_fire      = csync_q[1] ^ ev_seen_reg;
  assign rd_fire      = csync_q[0] ^ rd_seen_reg;
  assign powered_down = cfg_reg[adcrp_pkg::MODE_BIT] && !busy_reg;

  always_comb
  begin
    conv_next       = conv_reg;
    cfg_next        = cfg_reg;
    lo_next         = lo_reg;
    hi_next         = hi_reg;
    busy_next       = busy_reg;
    start_next      = 1'b0;
    snap_next       = snap_reg;
    rd_ack_tgl_next = rd_ack_tgl_reg;
    if (conv_done)
    begin
      conv_next = {conv_value, adcrp_pkg::CONV_PAD}; // RL14
      busy_next = 1'b0;
    end
    if (ev_fire && ev_gc_reg)
    begin
      conv_next = adcrp_pkg::CONV_RESET; // RL20
      cfg_next  = adcrp_pkg::CFG_RESET[adcrp_pkg::CFG_OS_BIT-1:0];
      lo_next   = adcrp_pkg::LO_RESET;
      hi_next   = adcrp_pkg::HI_RESET;
      busy_next = 1'b0;
    end
    else if (ev_fire)
    begin
      unique case (ptr_reg) // RL12
        adcrp_pkg::PTR_CONV: conv_next = conv_next; // RL23
        adcrp_pkg::PTR_CFG:
        begin
          cfg_next = ev_data_reg[adcrp_pkg::CFG_OS_BIT-1:0]; // RL16 RL17
          // a start while a conversion runs is ignored; set wins over done
          if (ev_data_reg[adcrp_pkg::CFG_OS_BIT] && powered_down)
          begin
            busy_next  = 1'b1; // RL22
            start_next = 1'b1;
          end
        end
        adcrp_pkg::PTR_LO:   lo_next = ev_data_reg;
        adcrp_pkg::PTR_HI:   hi_next = ev_data_reg;
      endcase
    end
    if (rd_fire)
    begin
      rd_ack_tgl_next = ~rd_ack_tgl_reg;
      unique case (ptr_reg) // RL7 RL12
        adcrp_pkg::PTR_CONV: snap_next = conv_reg;
        adcrp_pkg::PTR_CFG:  snap_next = {~busy_reg, cfg_reg}; // RL22
        adcrp_pkg::PTR_LO:   snap_next = lo_reg;
        adcrp_pkg::PTR_HI:   snap_next = hi_reg;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ev_seen_reg    <= 1'b0;
      rd_seen_reg    <= 1'b0;
      conv_reg       <= adcrp_pkg::CONV_RESET; // RL15
      cfg_reg        <= adcrp_pkg::CFG_RESET[adcrp_pkg::CFG_OS_BIT-1:0]; // RL16
      lo_reg         <= adcrp_pkg::LO_RESET;
      hi_reg         <= adcrp_pkg::HI_RESET;
      busy_reg       <= 1'b0;
      start_reg      <= 1'b0;
      snap_reg       <= '0;
      rd_ack_tgl_reg <= 1'b0;
    end
    else
    begin
      ev_seen_reg    <= csync_q[1];
      rd_seen_reg    <= csync_q[0];
      conv_reg       <= conv_next;
      cfg_reg        <= cfg_next;
      lo_reg         <= lo_next;
      hi_reg         <= hi_next;
      busy_reg       <= busy_next;
      start_reg      <= start_next;
      snap_reg       <= snap_next;
      rd_ack_tgl_reg <= rd_ack_tgl_next;
    end
  end

  assign conv_start     = start_reg;
  assign input_select   = cfg_reg[adcrp_pkg::MUX_MSB:adcrp_pkg::MUX_LSB]; // RL17
  assign gain_select    = cfg_reg[adcrp_pkg::GAIN_MSB:adcrp_pkg::GAIN_LSB];
  assign op_mode        = cfg_reg[adcrp_pkg::MODE_BIT];
  assign rate_select    = cfg_reg[adcrp_pkg::RATE_MSB:adcrp_pkg::RATE_LSB];
  assign comp_kind      = cfg_reg[adcrp_pkg::KIND_BIT];
  assign alert_polarity = cfg_reg[adcrp_pkg::POL_BIT];
  assign alert_latch    = cfg_reg[adcrp_pkg::LAT_BIT];
  assign alert_queue    = cfg_reg[adcrp_pkg::QUE_MSB:adcrp_pkg::QUE_LSB];
  assign low_limit      = lo_reg;
  assign high_limit     = hi_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_gc_reset;
    @(posedge clk) disable iff (!rst_b)
    (ev_fire && ev_gc_reg) |=> (conv_reg == adcrp_pkg::CONV_RESET) && op_mode && !busy_reg;
  endproperty
  a_gc_reset: assert property (p_gc_reset) else $error("general call reset not applied"); // RL20

  property p_conv_load;
    @(posedge clk) disable iff (!rst_b)
    (conv_done && !(ev_fire && ev_gc_reg)) |=> conv_reg == {$past(conv_value), adcrp_pkg::CONV_PAD};
  endproperty
  a_conv_load: assert property (p_conv_load) else $error("conversion result not stored"); // RL14

  property p_conv_ro;
    @(posedge clk) disable iff (!rst_b)
    (ev_fire && !ev_gc_reg && ptr_reg == adcrp_pkg::PTR_CONV && !conv_done) |=> $stable(conv_reg);
  endproperty
  a_conv_ro: assert property (p_conv_ro) else $error("conversion register was overwritten"); // RL23

  property p_os_start;
    @(posedge clk) disable iff (!rst_b)
    (ev_fire && !ev_gc_reg && ptr_reg == adcrp_pkg::PTR_CFG && ev_data_reg[adcrp_pkg::CFG_OS_BIT]
     && powered_down) |=> conv_start && busy_reg ##1 !conv_start;
  endproperty
  a_os_start: assert property (p_os_start) else $error("start flag did not begin a conversion"); // RL22

  property p_os_read;
    @(posedge clk) disable iff (!rst_b)
    (rd_fire && ptr_reg == adcrp_pkg::PTR_CFG) |=> snap_reg[adcrp_pkg::CFG_OS_BIT] == !$past(busy_reg);
  endproperty
  a_os_read: assert property (p_os_read) else $error("status flag read wrong"); // RL22

  property p_stop_release;
    @(posedge link_clk) disable iff (!link_rst_b)
    (stop_det && !start_det) |=> sda_oe_n && !hs_mode && st_reg == adcrp_pkg::ST_IDLE;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("data line held after stop"); // RL5

  property p_hs_code;
    @(posedge link_clk) disable iff (!link_rst_b)
    (st_reg == adcrp_pkg::ST_ADDR && scl_fall && !start_det && !stop_det && cnt_reg == adcrp_pkg::BITS_PER_BYTE
     && shift_reg[7:3] == adcrp_pkg::HS_CODE_TOP) |=> (hs_mode && sda_oe_n) [*2];
  endproperty
  a_hs_code: assert property (p_hs_code) else $error("master code handled wrongly"); // RL21

  property p_addr_ack;
    @(posedge link_clk) disable iff (!link_rst_b)
    (st_reg == adcrp_pkg::ST_ADDR && scl_fall && !start_det && !stop_det && cnt_reg == adcrp_pkg::BITS_PER_BYTE
     && shift_reg[7:1] == dev_addr) |=> !sda_oe_n && st_reg == adcrp_pkg::ST_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged"); // RL18

  property p_ptr_load;
    @(posedge link_clk) disable iff (!link_rst_b)
    (st_reg == adcrp_pkg::ST_PTR && scl_fall && !start_det && !stop_det && cnt_reg == adcrp_pkg::BITS_PER_BYTE)
    |=> ptr_reg == $past(shift_reg[1:0]) && !sda_oe_n;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not taken"); // RL1

  property p_tx_msb;
    @(posedge link_clk) disable iff (!link_rst_b)
    (st_reg == adcrp_pkg::ST_ACK && after_reg == adcrp_pkg::ST_TX && scl_fall && !start_det && !stop_det
     && snap_ok_reg) |=> st_reg == adcrp_pkg::ST_TX && sda_oe_n == $past(snap_reg[15]);
  endproperty
  a_tx_msb: assert property (p_tx_msb) else $error("upper byte not sent first"); // RL4
endmodule

// file: tb/adcrp_master.sv
// two-wire bus master model for the register port bench
`timescale 1ns/1ps
module adcrp_master (
  output logic      scl,   // bus clock, only ever driven here
  output logic      sda_m, // data drive, 1 releases to pull-up
  input  wire logic sda    // resolved data line
);
  localparam int HALF = 400; // half bit in ns, over six link clocks
  initial scl = 1'b1;
  initial sda_m = 1'b1;
  // ----
  // bit, byte and transfer tasks
  // ----
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    #HALF scl = 1'b1;
    #(HALF/2) r = sda;
    #(HALF/2) scl = 1'b0;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_m = 1'b0;
    #HALF scl = 1'b0;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_m = 1'b1;
    #HALF;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nk);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, nk);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
  task automatic wr(input logic [7:0] a, p, input logic [15:0] v, input logic two, output logic [2:0] nk);
    logic k;
    nk = 3'h0;
    start();
    wbyte(a, nk[2]);
    wbyte(p, nk[1]);
    if (two)
    begin
      wbyte(v[15:8], nk[0]);
      wbyte(v[7:0], k);
      nk[0] = nk[0] | k;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic nk);
    start();
    wbyte(a, nk);
    rbyte(1'b0, v[15:8]);
    rbyte(1'b1, v[7:0]);
    stop();
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench of the two-wire register port
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, conv_done = 1'b0, scl, sda_m;
  logic [1:0] address_strap = 2'h0;
  logic [11:0] conv_value = 12'h000;
  logic sda_o, sda_oe_n, hs_mode, conv_start, op_mode, comp_kind, alert_polarity, alert_latch;
  logic [2:0] input_select, gain_select, rate_select;
  logic [1:0] alert_queue;
  logic [15:0] low_limit, high_limit;
  logic [2:0] nk;
  int fails = 0, n_tests = 0, starts = 0;
  wire logic sda = sda_m & (sda_oe_n | sda_o);
  wire logic [15:0] cfgv = {1'b0, input_select, gain_select, op_mode, rate_select, comp_kind,
                            alert_polarity, alert_latch, alert_queue};
  always #5 clk = ~clk;
  always #32 link_clk = ~link_clk;
  always @(posedge clk) if (rst_b && conv_start === 1'b1) starts++;
  adcrp_port adcrp_port_i (.clk, .rst_b, .link_clk, .scl_i(scl), .sda_i(sda), .address_strap, .sda_o,
    .sda_oe_n, .hs_mode, .conv_value, .conv_done, .conv_start, .input_select, .gain_select, .op_mode,
    .rate_select, .comp_kind, .alert_polarity, .alert_latch, .alert_queue, .low_limit, .high_limit);
  adcrp_master adcrp_master_i (.scl, .sda_m, .sda);
  // ----
  // checks and scenarios
  // ----
  task automatic summarize();
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [1:0] p, input logic [15:0] v, input logic two);
    adcrp_master_i.wr(a, {6'h00, p}, v, two, nk);
    repeat (10) @(posedge clk);
  endtask
  task automatic rdcmp(input logic [1:0] p, input logic [15:0] exp);
    logic [15:0] v;
    logic n;
    wr(8'h90, p, 16'h0000, 1'b0);
    adcrp_master_i.rd(8'h91, v, n);
    cmp({12'h000, nk[2:1], n, 1'b0}, 16'h0000);
    cmp(v, exp);
  endtask
  task automatic t_conv();
    wr(8'h90, adcrp_pkg::PTR_CFG, 16'h8583, 1'b1);
    cmp(16'(starts), 16'h0001);
    rdcmp(adcrp_pkg::PTR_CFG, 16'h0583);
    @(posedge clk);
    conv_value <= 12'habc;
    conv_done  <= 1'b1;
    @(posedge clk);
    conv_done  <= 1'b0;
    rdcmp(adcrp_pkg::PTR_CONV, 16'habc0);
    wr(8'h90, adcrp_pkg::PTR_CONV, 16'h1111, 1'b1);
    cmp({13'h0000, nk}, 16'h0000);
    rdcmp(adcrp_pkg::PTR_CONV, 16'habc0);
  endtask
  task automatic t_regs();
    wr(8'h90, adcrp_pkg::PTR_CFG, 16'h0483, 1'b1);
    cmp(cfgv, 16'h0483);
    rdcmp(adcrp_pkg::PTR_CFG, 16'h8483);
    wr(8'h90, adcrp_pkg::PTR_LO, 16'h1234, 1'b1);
    wr(8'h90, adcrp_pkg::PTR_HI, 16'h5678, 1'b1);
    cmp(low_limit, 16'h1234);
    cmp(high_limit, 16'h5678);
    rdcmp(adcrp_pkg::PTR_LO, 16'h1234);
  endtask
  task automatic t_gcall();
    logic [15:0] v;
    logic n;
    adcrp_master_i.wr(8'h00, adcrp_pkg::GCALL_RESET, 16'h0000, 1'b0, nk);
    cmp({13'h0000, nk}, 16'h0000);
    cmp(cfgv, 16'h0583);
    cmp(low_limit, adcrp_pkg::LO_RESET);
    cmp(high_limit, adcrp_pkg::HI_RESET);
    adcrp_master_i.rd(8'h91, v, n);
    cmp({15'h0000, n}, 16'h0000);
    cmp(v, adcrp_pkg::CONV_RESET);
  endtask
  task automatic t_hs();
    logic n;
    adcrp_master_i.start();
    adcrp_master_i.wbyte(8'h09, n);
    cmp({13'h0000, sda_o, n, hs_mode}, 16'h0003);
    adcrp_master_i.stop();
    cmp({15'h0000, hs_mode}, 16'h0000);
  endtask
  task automatic t_addr();
    address_strap <= 2'h2;
    wr(8'h94, adcrp_pkg::PTR_CFG, 16'h0000, 1'b0);
    cmp({13'h0000, nk}, 16'h0000);
    wr(8'h90, adcrp_pkg::PTR_CFG, 16'h0000, 1'b0);
    cmp({13'h0000, nk}, 16'h0006);
    address_strap <= 2'h1;
    wr(8'h92, adcrp_pkg::PTR_CFG, 16'h0000, 1'b0);
    cmp({13'h0000, nk}, 16'h0000);
    address_strap <= 2'h3;
    wr(8'h96, adcrp_pkg::PTR_CFG, 16'h0000, 1'b0);
    cmp({13'h0000, nk}, 16'h0000);
  endtask
  initial
  begin
    #650000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk);
    rdcmp(adcrp_pkg::PTR_CONV, 16'h0000);
    cmp(cfgv, 16'h0583);
    t_conv();
    t_regs();
    t_gcall();
    t_hs();
    t_addr();
    summarize();
  end
endmodule
